// ### hw/aipp_pace_timer.sv
`timescale 1ns/10ps
module aipp_pace_timer (
    // Clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_rst_n,
    // Control
    input  wire logic                        i_restart,
    input  wire logic [aipp_pkg::CNT_W-1:0]  i_load_val,
    // Status
    output logic                             o_expired
);

    logic [aipp_pkg::CNT_W-1:0]  cnt_r;
    logic [aipp_pkg::CNT_W-1:0]  cnt_nxt;
    logic [aipp_pkg::TICK_W-1:0] tick_r;
    logic [aipp_pkg::TICK_W-1:0] tick_nxt;

    localparam logic [aipp_pkg::TICK_W-1:0] TICK_LAST =
        aipp_pkg::TICK_W'(aipp_pkg::PACE_TICK_CYC - 1);

    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = tick_r;
        if (i_restart) begin
            cnt_nxt  = i_load_val;
            tick_nxt = '0;
        end else if (cnt_r != aipp_pkg::CNT_ZERO) begin
            if (tick_r == TICK_LAST) begin
                tick_nxt = '0;
                cnt_nxt  = cnt_r - aipp_pkg::CNT_W'(1);
            end else begin
                tick_nxt = tick_r + aipp_pkg::TICK_W'(1);
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r  <= '0;
            tick_r <= '0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign o_expired = (cnt_r == aipp_pkg::CNT_ZERO);

endmodule : aipp_pace_timer

// ### hw/aipp_pkg.sv
package aipp_pkg;

    // Clock and pacing time base
    localparam int CLK_PERIOD_NS = 8;
    localparam int PACE_TICK_NS  = 4000;
    localparam int PACE_TICK_CYC = (PACE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W        = 9;

    // Sizes
    localparam int NUM_TX = 8;
    localparam int TXI_W  = 3;
    localparam int CNT_W  = 8;
    localparam int CHAN_W = 8;
    localparam int VEC_W  = 16;

    // Vector and command word layout, shared bit for bit
    localparam int TYPE_LSB = 2;
    localparam int TYPE_MSB = 4;
    localparam int CHAN_LSB = 5;
    localparam int CHAN_MSB = 12;

    // Channel codes of the status type
    localparam logic [CHAN_W-1:0] NET_CHAN   = 8'h00;
    localparam logic [CHAN_W-1:0] ADCHK_CHAN = 8'hff;

    // Reset values of the loadable settings, and counter limits
    localparam logic [CNT_W-1:0] DEF_PACE = 8'h00;
    localparam logic [CNT_W-1:0] DEF_THR  = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX  = 8'hff;

    typedef enum logic [2:0] {
        IT_NONE   = 3'h0,
        IT_TX_EOF = 3'h1,
        IT_STAT   = 3'h2,
        IT_RX_EOF = 3'h3,
        IT_DUMMY  = 3'h4,
        IT_TX_EOC = 3'h5,
        IT_STATUS = 3'h6,
        IT_RX_EOC = 3'h7
    } aipp_itype_type;

endpackage : aipp_pkg

// ### hw/aipp_top.sv
`timescale 1ns/10ps
module aipp_top (
    // Clock and reset
    input  wire logic                            I_CLOCK,
    input  wire logic                            I_RST_N,
    // Adapter event pulses
    input  wire logic                            I_ADCHK_EVT,
    input  wire logic                            I_NET_EVT,
    input  wire logic                            I_STAT_EVT,
    input  wire logic [aipp_pkg::NUM_TX-1:0]     I_TX_EOF_EVT,
    input  wire logic [aipp_pkg::NUM_TX-1:0]     I_TX_EOC_EVT,
    input  wire logic                            I_RX_EOF_EVT,
    input  wire logic                            I_RX_EOC_EVT,
    // Vector register access
    input  wire logic                            I_VEC_RD,
    input  wire logic                            I_VEC_WR,
    // Command register write
    input  wire logic                            I_CMD_WR,
    input  wire logic [aipp_pkg::VEC_W-1:0]      I_CMD_VEC,
    input  wire logic                            I_CMD_ACK,
    input  wire logic                            I_CMD_GO,
    input  wire logic                            I_CMD_REQ_INT,
    input  wire logic                            I_CMD_AD_RST,
    input  wire logic                            I_CMD_INTS_ON,
    input  wire logic                            I_CMD_INTS_OFF,
    input  wire logic                            I_CMD_LD_TMR,
    input  wire logic                            I_CMD_TX_EVENT_THRESHOLD,
    input  wire logic [aipp_pkg::CNT_W-1:0]      I_CMD_ACK_COUNT,
    // Outputs
    output logic                                 O_INT_REQ,
    output logic [aipp_pkg::VEC_W-1:0]           O_VEC_DATA,
    output logic [aipp_pkg::NUM_TX-1:0]          O_TX_GO,
    output logic                                 O_RX_GO,
    output logic                                 O_ADAPTER_RESET,
    output logic                                 O_INTS_EN
);

    localparam int NT      = aipp_pkg::NUM_TX;
    localparam int CW      = aipp_pkg::CNT_W;
    localparam int TXI_W_L = aipp_pkg::TXI_W;

    // Command decode
    aipp_pkg::aipp_itype_type      ack_type;
    logic [aipp_pkg::CHAN_W-1:0]   ack_chan;
    logic                          ack_wr;
    logic                          soft_rst;
    logic                          in_check;
    logic                          chan_ok;

    assign ack_type = aipp_pkg::aipp_itype_type'(I_CMD_VEC[aipp_pkg::TYPE_MSB:aipp_pkg::TYPE_LSB]);
    assign ack_chan = I_CMD_VEC[aipp_pkg::CHAN_MSB:aipp_pkg::CHAN_LSB];
    assign ack_wr   = I_CMD_WR & I_CMD_ACK;
    assign soft_rst = I_CMD_WR & I_CMD_AD_RST;
    assign chan_ok  = (ack_chan < aipp_pkg::CHAN_W'(NT));

    // Single flags and settings
    logic            adchk_r, adchk_nxt;
    logic            net_r, net_nxt;
    logic            stat_r, stat_nxt;
    logic            dummy_r, dummy_nxt;
    logic            rx_eoc_r, rx_eoc_nxt;
    logic [CW-1:0]   rx_cnt_r, rx_cnt_nxt;
    logic [CW-1:0]   thr_r, thr_nxt;
    logic [CW-1:0]   pace_r, pace_nxt;
    logic            ints_en_r, ints_en_nxt;
    logic            rr_r, rr_nxt;
    logic            irq_r, irq_nxt;
    logic [aipp_pkg::VEC_W-1:0] vec_r, vec_nxt;
    logic [NT-1:0]   tx_go_r, tx_go_nxt;
    logic            rx_go_r, rx_go_nxt;
    logic            adrst_r, adrst_nxt;

    // Per channel transmit state
    logic [CW-1:0]   tx_cnt_r [NT];
    logic [NT-1:0]   tx_eoc_r;
    logic [NT-1:0]   tx_eof_rep;
    logic [NT-1:0]   tx_eoc_rep;
    logic [NT-1:0]   tx_nz;

    logic            rx_eof_rep, rx_eoc_rep, any_pend, expired;
    aipp_pkg::aipp_itype_type sel_type;
    logic [aipp_pkg::CHAN_W-1:0] sel_chan;

    // Internal reset holds while the adapter is in check
    assign in_check = adchk_r | I_ADCHK_EVT;

    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++) begin : g_tx
            logic [CW-1:0] cnt_nxt;
            logic [CW-1:0] dec;
            logic [CW-1:0] sub;
            logic          eoc_nxt;
            logic          hit;

            assign hit = ack_wr & chan_ok & (ack_chan == aipp_pkg::CHAN_W'(gi));
            assign tx_nz[gi] = (tx_cnt_r[gi] != aipp_pkg::CNT_ZERO);
            assign tx_eof_rep[gi] = (thr_r != aipp_pkg::CNT_ZERO) & tx_nz[gi] &
                                    ((tx_cnt_r[gi] >= thr_r) | tx_eoc_r[gi]);
            assign tx_eoc_rep[gi] = tx_eoc_r[gi] & ~(|tx_nz);

            always_comb begin
                dec = aipp_pkg::CNT_ZERO;
                if (hit && ack_type == aipp_pkg::IT_TX_EOF) begin
                    dec = (I_CMD_ACK_COUNT > tx_cnt_r[gi]) ? tx_cnt_r[gi] : I_CMD_ACK_COUNT;
                end
                sub     = tx_cnt_r[gi] - dec;
                cnt_nxt = sub;
                // no EOF counting at threshold zero
                if (I_TX_EOF_EVT[gi] && thr_r != aipp_pkg::CNT_ZERO &&
                    sub != aipp_pkg::CNT_MAX) begin
                    cnt_nxt = sub + CW'(1);
                end
                eoc_nxt = (tx_eoc_r[gi] & ~(hit && ack_type == aipp_pkg::IT_TX_EOC)) |
                          I_TX_EOC_EVT[gi];
                if (in_check || soft_rst) begin
                    cnt_nxt = aipp_pkg::CNT_ZERO;
                    eoc_nxt = 1'b0;
                end
            end

            always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    tx_cnt_r[gi] <= '0;
                    tx_eoc_r[gi] <= 1'b0;
                end else begin
                    tx_cnt_r[gi] <= cnt_nxt;
                    tx_eoc_r[gi] <= eoc_nxt;
                end
            end
        end
    endgenerate

    assign rx_eof_rep = (rx_cnt_r != aipp_pkg::CNT_ZERO);
    assign rx_eoc_rep = rx_eoc_r & ~rx_eof_rep;
    assign any_pend   = adchk_r | net_r | stat_r | dummy_r | rx_eof_rep | rx_eoc_rep |
                        (|tx_eof_rep) | (|tx_eoc_rep);

    // Priority select of the reported source
    always_comb begin
        logic                 eof_hit;
        logic                 eoc_hit;
        logic                 tx_av;
        logic                 rx_av;
        logic [TXI_W_L-1:0]   eof_ch;
        logic [TXI_W_L-1:0]   eoc_ch;
        eof_hit  = 1'b0;
        eoc_hit  = 1'b0;
        eof_ch   = '0;
        eoc_ch   = '0;
        tx_av    = 1'b0;
        rx_av    = 1'b0;
        for (int i = 0; i < NT; i++) begin
            if (tx_eof_rep[i]) begin
                eof_hit = 1'b1;
                eof_ch  = TXI_W_L'(i);
            end
            if (tx_eoc_rep[i]) begin
                eoc_hit = 1'b1;
                eoc_ch  = TXI_W_L'(i);
            end
        end
        tx_av    = eof_hit | eoc_hit;
        rx_av    = rx_eof_rep | rx_eoc_rep;
        sel_type = aipp_pkg::IT_NONE;
        sel_chan = aipp_pkg::NET_CHAN;
        if (adchk_r) begin
            sel_type = aipp_pkg::IT_STATUS;
            sel_chan = aipp_pkg::ADCHK_CHAN;
        end else if (net_r) begin
            sel_type = aipp_pkg::IT_STATUS;
        end else if (stat_r) begin
            sel_type = aipp_pkg::IT_STAT;
        end else if (dummy_r) begin
            sel_type = aipp_pkg::IT_DUMMY;
        end else if (rx_av && (rr_r || !tx_av)) begin
            sel_type = rx_eof_rep ? aipp_pkg::IT_RX_EOF : aipp_pkg::IT_RX_EOC;
        end else if (eof_hit) begin
            sel_type = aipp_pkg::IT_TX_EOF;
            sel_chan = aipp_pkg::CHAN_W'(eof_ch);
        end else if (eoc_hit) begin
            sel_type = aipp_pkg::IT_TX_EOC;
            sel_chan = aipp_pkg::CHAN_W'(eoc_ch);
        end
    end

    // Next values of the single flags and outputs
    always_comb begin
        logic [CW-1:0] rdec;
        logic [CW-1:0] rsub;
        rdec = aipp_pkg::CNT_ZERO;
        rsub = aipp_pkg::CNT_ZERO;
        adchk_nxt = (adchk_r & ~soft_rst) | I_ADCHK_EVT;
        net_nxt   = (net_r & ~(ack_wr && ack_type == aipp_pkg::IT_STATUS &&
                     ack_chan == aipp_pkg::NET_CHAN)) | I_NET_EVT;
        stat_nxt  = (stat_r & ~(ack_wr && ack_type == aipp_pkg::IT_STAT)) | I_STAT_EVT;
        dummy_nxt = (dummy_r & ~(ack_wr && ack_type == aipp_pkg::IT_DUMMY)) |
                    (I_CMD_WR & I_CMD_REQ_INT);
        rx_eoc_nxt = (rx_eoc_r & ~(ack_wr && ack_type == aipp_pkg::IT_RX_EOC)) | I_RX_EOC_EVT;
        if (ack_wr && ack_type == aipp_pkg::IT_RX_EOF) begin
            rdec = (I_CMD_ACK_COUNT > rx_cnt_r) ? rx_cnt_r : I_CMD_ACK_COUNT;
        end
        rsub       = rx_cnt_r - rdec;
        rx_cnt_nxt = (I_RX_EOF_EVT && rsub != aipp_pkg::CNT_MAX) ? rsub + CW'(1) : rsub;
        if (in_check || soft_rst) begin
            net_nxt    = 1'b0;
            stat_nxt   = 1'b0;
            dummy_nxt  = 1'b0;
            rx_eoc_nxt = 1'b0;
            rx_cnt_nxt = aipp_pkg::CNT_ZERO;
        end
        thr_nxt  = soft_rst ? aipp_pkg::DEF_THR :
                   (I_CMD_WR && I_CMD_TX_EVENT_THRESHOLD) ? I_CMD_ACK_COUNT : thr_r;
        pace_nxt = soft_rst ? aipp_pkg::DEF_PACE :
                   (I_CMD_WR && I_CMD_LD_TMR) ? I_CMD_ACK_COUNT : pace_r;
        ints_en_nxt = ints_en_r;
        if (I_CMD_WR && (I_CMD_INTS_ON || I_CMD_ACK)) begin
            ints_en_nxt = 1'b1;
        end else if (soft_rst || I_VEC_WR || (I_CMD_WR && I_CMD_INTS_OFF)) begin
            ints_en_nxt = 1'b0;
        end
        rr_nxt = rr_r;
        if (ack_wr && (ack_type == aipp_pkg::IT_TX_EOF || ack_type == aipp_pkg::IT_TX_EOC)) begin
            rr_nxt = 1'b1;
        end else if (ack_wr && (ack_type == aipp_pkg::IT_RX_EOF ||
                                ack_type == aipp_pkg::IT_RX_EOC)) begin
            rr_nxt = 1'b0;
        end
        vec_nxt = vec_r;
        if (I_VEC_RD) begin
            vec_nxt = '0;
            vec_nxt[aipp_pkg::TYPE_MSB:aipp_pkg::TYPE_LSB] = sel_type;
            vec_nxt[aipp_pkg::CHAN_MSB:aipp_pkg::CHAN_LSB] = sel_chan;
        end
        // go taken with the same write
        tx_go_nxt = '0;
        rx_go_nxt = 1'b0;
        if (I_CMD_WR && I_CMD_GO) begin
            if (ack_type == aipp_pkg::IT_RX_EOF || ack_type == aipp_pkg::IT_RX_EOC) begin
                rx_go_nxt = 1'b1;
            end else if (chan_ok) begin
                tx_go_nxt = NT'(1) << ack_chan[TXI_W_L-1:0];
            end
        end
        adrst_nxt = I_ADCHK_EVT & ~adchk_r;
        // falls on ack or nothing pending
        irq_nxt = ints_en_r & expired & any_pend & ~ack_wr;
    end

    aipp_pace_timer u_pace (
        .i_clock    (I_CLOCK),
        .i_rst_n    (I_RST_N),
        .i_restart  (ack_wr | soft_rst),
        .i_load_val (pace_r),
        .o_expired  (expired)
    );

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            adchk_r   <= 1'b0;
            net_r     <= 1'b0;
            stat_r    <= 1'b0;
            dummy_r   <= 1'b0;
            rx_eoc_r  <= 1'b0;
            rx_cnt_r  <= aipp_pkg::CNT_ZERO;
            thr_r     <= aipp_pkg::DEF_THR;
            pace_r    <= aipp_pkg::DEF_PACE;
            ints_en_r <= 1'b0;
            rr_r      <= 1'b0;
            irq_r     <= 1'b0;
            vec_r     <= '0;
            tx_go_r   <= '0;
            rx_go_r   <= 1'b0;
            adrst_r   <= 1'b0;
        end else begin
            adchk_r   <= adchk_nxt;
            net_r     <= net_nxt;
            stat_r    <= stat_nxt;
            dummy_r   <= dummy_nxt;
            rx_eoc_r  <= rx_eoc_nxt;
            rx_cnt_r  <= rx_cnt_nxt;
            thr_r     <= thr_nxt;
            pace_r    <= pace_nxt;
            ints_en_r <= ints_en_nxt;
            rr_r      <= rr_nxt;
            irq_r     <= irq_nxt;
            vec_r     <= vec_nxt;
            tx_go_r   <= tx_go_nxt;
            rx_go_r   <= rx_go_nxt;
            adrst_r   <= adrst_nxt;
        end
    end

    assign O_INT_REQ       = irq_r;
    assign O_VEC_DATA      = vec_r;
    assign O_TX_GO         = tx_go_r;
    assign O_RX_GO         = rx_go_r;
    assign O_ADAPTER_RESET = adrst_r;
    assign O_INTS_EN       = ints_en_r;

    a_irq_cause: assert property (
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        O_INT_REQ |-> $past(expired) && $past(any_pend) && $past(ints_en_r))
        else $error("Interrupt raised without expiry and pending source");

    a_ack_restart: assert property (
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (ack_wr && pace_r != aipp_pkg::CNT_ZERO) |=> !expired ##1 !O_INT_REQ)
        else $error("Acknowledge did not restart pacing timer");

    a_vec_snapshot: assert property (
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        I_VEC_RD |=> O_VEC_DATA[aipp_pkg::TYPE_MSB:aipp_pkg::TYPE_LSB] == $past(sel_type))
        else $error("Vector read does not match selected source");

    a_vec_lsb_zero: assert property (
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        O_VEC_DATA[aipp_pkg::TYPE_LSB-1:0] == '0)
        else $error("Vector low bits not zero");

    a_adchk_clears: assert property (
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        adchk_r |-> !net_r && !stat_r && !dummy_r && rx_cnt_r == aipp_pkg::CNT_ZERO)
        else $error("Sources survive adapter check");

    a_adchk_sticky: assert property (
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (adchk_r && !soft_rst) |=> adchk_r && sel_chan == aipp_pkg::ADCHK_CHAN)
        else $error("Adapter check cleared without reset");

    a_rx_eoc_wait: assert property (
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (I_VEC_RD && rx_cnt_r != aipp_pkg::CNT_ZERO) |=>
        O_VEC_DATA[aipp_pkg::TYPE_MSB:aipp_pkg::TYPE_LSB] != aipp_pkg::IT_RX_EOC)
        else $error("Receive EOC reported with EOF pending");
    a_tx_eoc_wait: assert property (
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (I_VEC_RD && tx_nz != '0) |=>
        O_VEC_DATA[aipp_pkg::TYPE_MSB:aipp_pkg::TYPE_LSB] != aipp_pkg::IT_TX_EOC)
        else $error("Transmit EOC reported with EOF pending");

    a_vec_wr_off: assert property (
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (I_VEC_WR && !I_CMD_WR) |=> !O_INTS_EN ##1 !O_INT_REQ)
        else $error("Vector write did not disable interrupts");

    a_thr_zero: assert property (
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (I_VEC_RD && thr_r == aipp_pkg::CNT_ZERO) |=>
        O_VEC_DATA[aipp_pkg::TYPE_MSB:aipp_pkg::TYPE_LSB] != aipp_pkg::IT_TX_EOF)
        else $error("Transmit EOF reported at threshold zero");
    a_dummy_set: assert property (
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (I_CMD_WR && I_CMD_REQ_INT && !in_check && !soft_rst) |=> dummy_r)
        else $error("Software request did not create dummy interrupt");

endmodule : aipp_top

// ### tb/aipp_host_model.sv
`timescale 1ns/10ps
module aipp_host_model (
    // Clock
    input  wire logic        i_clock,
    // Vector register
    input  wire logic [15:0] i_vec_data,
    output logic             o_vec_rd,
    output logic             o_vec_wr,
    // Command register, flags {ldthr,ldtmr,off,on,rst,req,go,ack}
    output logic             o_cmd_wr,
    output logic [15:0]      o_cmd_vec,
    output logic [7:0]       o_flags,
    output logic [7:0]       o_count
);
    initial begin
        o_vec_rd = 1'b0;
        o_vec_wr = 1'b0;
        o_cmd_wr = 1'b0;
        o_cmd_vec = 16'h0000;
        o_flags = 8'h00;
        o_count = 8'h00;
    end
    task automatic rd_vec(output logic [15:0] v);
        @(posedge i_clock);
        #1 o_vec_rd = 1'b1;
        @(posedge i_clock);
        #1 o_vec_rd = 1'b0;
        v = i_vec_data;
    endtask : rd_vec
    task automatic wr_vec();
        @(posedge i_clock);
        #1 o_vec_wr = 1'b1;
        @(posedge i_clock);
        #1 o_vec_wr = 1'b0;
    endtask : wr_vec
    task automatic cmd(input logic [15:0] v, input logic [7:0] f, input logic [7:0] c);
        @(posedge i_clock);
        #1 o_cmd_wr = 1'b1;
        o_cmd_vec = v;
        o_flags = f;
        o_count = c;
        @(posedge i_clock);
        #1 o_cmd_wr = 1'b0;
        o_flags = 8'h00;
        // Released fields flip so stale data never looks valid
        o_cmd_vec = ~o_cmd_vec;
        o_count = ~o_count;
    endtask : cmd
endmodule : aipp_host_model

// ### tb/aipp_tb_top.sv
`timescale 1ns/10ps
module aipp_tb_top;
    localparam logic [7:0] ACK = 8'h01, GO = 8'h02, REQ = 8'h04, RST = 8'h08;
    localparam logic [7:0] ON = 8'h10, OFF = 8'h20, LDTMR = 8'h40, LDTHR = 8'h80;
    logic        clk;
    logic        rst_n;
    logic [20:0] e;
    logic [15:0] vdata;
    logic        vrd, vwr, cwr;
    logic [15:0] cvec;
    logic [7:0]  fl, cnt, txgo;
    logic        irq, rxgo, adrst, inten;
    int          fails, n_compared, cyc;

    aipp_top aipp_top_i (.I_CLOCK(clk), .I_RST_N(rst_n), .I_ADCHK_EVT(e[20]),
        .I_NET_EVT(e[19]), .I_STAT_EVT(e[18]), .I_RX_EOF_EVT(e[17]),
        .I_RX_EOC_EVT(e[16]), .I_TX_EOC_EVT(e[15:8]), .I_TX_EOF_EVT(e[7:0]),
        .I_VEC_RD(vrd), .I_VEC_WR(vwr), .I_CMD_WR(cwr), .I_CMD_VEC(cvec),
        .I_CMD_ACK(fl[0]), .I_CMD_GO(fl[1]), .I_CMD_REQ_INT(fl[2]),
        .I_CMD_AD_RST(fl[3]), .I_CMD_INTS_ON(fl[4]), .I_CMD_INTS_OFF(fl[5]),
        .I_CMD_LD_TMR(fl[6]), .I_CMD_TX_EVENT_THRESHOLD(fl[7]), .I_CMD_ACK_COUNT(cnt),
        .O_INT_REQ(irq), .O_VEC_DATA(vdata), .O_TX_GO(txgo), .O_RX_GO(rxgo),
        .O_ADAPTER_RESET(adrst), .O_INTS_EN(inten));
    aipp_host_model aipp_host_model_i (.i_clock(clk), .i_vec_data(vdata),
        .o_vec_rd(vrd), .o_vec_wr(vwr), .o_cmd_wr(cwr), .o_cmd_vec(cvec),
        .o_flags(fl), .o_count(cnt));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            results();
        end
    end

    function automatic logic [15:0] vec(input logic [2:0] t, input logic [7:0] c);
        vec = 16'h0000;
        vec[aipp_pkg::TYPE_MSB:aipp_pkg::TYPE_LSB] = t;
        vec[aipp_pkg::CHAN_MSB:aipp_pkg::CHAN_LSB] = c;
    endfunction : vec
    task automatic chk1(input logic g, input logic x);
        n_compared++;
        if (g !== x) begin
            fails++;
            $display("[FAIL] %0t flag %b expected %b", $time, g, x);
        end
    endtask : chk1
    task automatic chk16(input logic [15:0] g, input logic [15:0] x);
        n_compared++;
        if (g !== x) begin
            fails++;
            $display("[FAIL] %0t value %h expected %h", $time, g, x);
        end
    endtask : chk16
    task automatic ev(input logic [20:0] m);
        @(posedge clk);
        #1 e = m;
        @(posedge clk);
        #1 e = 21'h000000;
    endtask : ev
    task automatic rv(input logic [2:0] t, input logic [7:0] c);
        logic [15:0] v;
        aipp_host_model_i.rd_vec(v);
        chk16(v, vec(t, c));
    endtask : rv
    task automatic ack(input logic [2:0] t, input logic [7:0] c, input logic [7:0] n,
                       input logic [7:0] f);
        aipp_host_model_i.cmd(vec(t, c), ACK | f, n);
    endtask : ack
    task automatic results();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    initial begin
        rst_n = 1'b0;
        e = 21'h000000;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        chk1(inten, 1'b0);
        aipp_host_model_i.cmd(16'h0000, ON, 8'h00);
        ev(21'h080000);
        repeat (2) @(posedge clk);
        #1 chk1(irq, 1'b1);
        aipp_host_model_i.wr_vec();
        @(posedge clk);
        #1 chk1(inten | irq, 1'b0);
        rv(3'h6, 8'h00);
        ack(3'h6, 8'h00, 8'h01, 8'h00);
        chk1(inten, 1'b1);
        rv(3'h0, 8'h00);
        aipp_host_model_i.cmd(16'h0000, OFF, 8'h00);
        ev(21'h080000);
        repeat (2) @(posedge clk);
        #1 chk1(irq | inten, 1'b0);
        ev(21'h0e0001);
        rv(3'h6, 8'h00);
        ack(3'h6, 8'h00, 8'h01, 8'h00);
        rv(3'h2, 8'h00);
        ack(3'h2, 8'h00, 8'h01, 8'h00);
        rv(3'h1, 8'h00);
        ack(3'h1, 8'h00, 8'h01, 8'h00);
        rv(3'h3, 8'h00);
        ack(3'h3, 8'h00, 8'h01, 8'h00);
        ev(21'h002024);
        rv(3'h1, 8'h05);
        ack(3'h1, 8'h05, 8'h01, 8'h00);
        rv(3'h1, 8'h02);
        ack(3'h1, 8'h02, 8'h01, 8'h00);
        rv(3'h5, 8'h05);
        ack(3'h5, 8'h05, 8'h01, GO);
        chk16({8'h00, txgo}, 16'h0020);
        ev(21'h030000);
        ev(21'h020000);
        rv(3'h3, 8'h00);
        ack(3'h3, 8'h00, 8'h02, GO);
        chk1(rxgo, 1'b1);
        rv(3'h7, 8'h00);
        ack(3'h7, 8'h00, 8'h01, 8'h00);
        aipp_host_model_i.cmd(16'h0000, REQ, 8'h00);
        rv(3'h4, 8'h00);
        ack(3'h4, 8'h00, 8'h01, 8'h00);
        aipp_host_model_i.cmd(16'h0000, LDTHR, 8'h03);
        ev(21'h000002);
        ev(21'h000002);
        rv(3'h0, 8'h00);
        ev(21'h000002);
        rv(3'h1, 8'h01);
        ack(3'h1, 8'h01, 8'h03, 8'h00);
        rv(3'h0, 8'h00);
        aipp_host_model_i.cmd(16'h0000, LDTHR, 8'h00);
        ev(21'h000002);
        rv(3'h0, 8'h00);
        aipp_host_model_i.cmd(16'h0000, LDTHR | LDTMR, 8'h01);
        ev(21'h080000);
        rv(3'h6, 8'h00);
        ack(3'h6, 8'h00, 8'h01, 8'h00);
        ev(21'h040000);
        repeat (400) @(posedge clk);
        #1 chk1(irq, 1'b0);
        for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk);
        #1 chk1(irq, 1'b1);
        aipp_host_model_i.cmd(16'h0000, LDTMR, 8'h00);
        ack(3'h2, 8'h00, 8'h01, 8'h00);
        ev(21'h080000);
        ev(21'h100000);
        chk1(adrst, 1'b1);
        rv(3'h6, 8'hff);
        ack(3'h6, 8'hff, 8'h01, 8'h00);
        rv(3'h6, 8'hff);
        aipp_host_model_i.cmd(16'h0000, RST, 8'h00);
        rv(3'h0, 8'h00);
        results();
    end
endmodule : aipp_tb_top
